// *** rtl/tpw_defines.svh ***
// Purpose: constants for the trickle power wake block
// Assumes: included by bare name
// Notes: register offsets are byte addresses of one-byte registers
`ifndef TPW_DEFINES_SVH
`define TPW_DEFINES_SVH
`define TPW_NUM_SRC        8
`define TPW_SRC_RI1        0
`define TPW_SRC_RI2        1
`define TPW_SRC_KBD        2
`define TPW_SRC_MOUSE      3
`define TPW_SRC_CIR        4
`define TPW_SRC_KEY        5
`define TPW_SRC_TACH       6
`define TPW_SRC_GPIO       7
`define TPW_ADDR_STATUS    8'h00
`define TPW_ADDR_ENABLE    8'h01
`define TPW_ADDR_MASK      8'h02
`define TPW_ADDR_IRQ_STAT  8'h03
`define TPW_ADDR_CTRL      8'h04
`define TPW_ADDR_GPCFG     8'h05
`define TPW_ADDR_PINSTATE  8'h06
`define TPW_CTRL_SP2_ACT   0
`define TPW_CTRL_SERIAL2_TRANSMIT_SEL  1
`define TPW_CTRL_IR_EN     2
`define TPW_CTRL_LED_A     3
`define TPW_CTRL_LED_B     4
`define TPW_GPCFG_DIR      0
`define TPW_GPCFG_INV      1
`define TPW_GPCFG_OD       2
`define TPW_GPCFG_OUT      3
`define TPW_RST_BYTE       8'h00
// raw source levels while the synchroniser sits in reset
`define TPW_RAW_IDLE       8'h0F
`endif

// *** rtl/tpw_pkg.sv ***
// Purpose: types for the trickle power wake block
// Assumes: tpw_defines.svh
// Notes: none
package tpw_pkg;
   typedef enum logic [1:0] {TPW_OFF, TPW_MAIN_ON} tpw_power_t;
   typedef struct packed {
      logic ring_ind1_n;
      logic ring_ind2_n;
      logic kbd_data_in;
      logic mouse_data_in;
      logic cir_rx2_pin;
      logic gpio_wake;
   } tpw_pins_t;
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] enable;
      logic [7:0] mask;
      logic [7:0] irq_stat;
      logic [7:0] ctrl;
      logic [7:0] gpcfg;
      logic [7:0] rdata;
      tpw_power_t power;
   } tpw_state_t;
endpackage

// *** rtl/tpw_sync.sv ***
// Purpose: two flop synchroniser for a vector of pins
// Assumes: one clock
// Notes: first stage read only by second
`timescale 1ns/1ps
module tpw_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= '0;
         dout   <= '0;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // tpw_sync

// *** rtl/tpw_wake.sv ***
// Purpose: trickle domain wake logic, wake request and standby pin control
// Assumes: clk from trickle domain; pins asynchronous
// Notes: reset is the trickle power-on reset; main_por and hard_reset are pulses
// How it works
// - enabled wake sources pull the wake request low, with or without main power
// - ring indicators, keyboard, mouse, infrared, key, tach, gpio are sources
// - tach wake works with main off; software clears its enable first
// - main-powered pins are inputs only on trickle, wake paths stay live
// - second infrared receive pin feeds only the infrared wake source
// - fan control pins driven low after main por and hard reset
// - shared transmit pin driven low after any reset, never a wake input
// - retained pin goes plain gpio without main, keeps dir, invert, type
// - three non-wake pins never reach the wake logic
// - wake request pin stays drivable on trickle supply
// - led pins driven by led logic even without main supply
// - second ir transmit low after main por until port 2 activated
// - shared pin low until serial selected and activated, then ir or serial
// - wake registers, infrared, key, led, tach state kept on trickle
// - every enabled power event asserts the open-drain active-low wake request
// - trickle por initialises all trickle registers
// - no register access decoded while main power good is low
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_wake
   import tpw_pkg::*;
#(
   parameter int NUM_SRC = `TPW_NUM_SRC
) (
   // clock and resets
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             main_por,
   input  wire logic             hard_reset,
   input  wire logic             main_power_good,
   // register port
   input  wire logic [7:0]       addr,
   input  wire logic [7:0]       wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [7:0]       rdata,
   // wake and non-wake pins
   input  wire tpw_pins_t        pins,
   input  wire logic             consumer_infrared,
   input  wire logic             key_match,
   input  wire logic             tach_event,
   input  wire logic             non_wake_pin_a,
   input  wire logic             non_wake_pin_b,
   input  wire logic             non_wake_pin_c,
   // wake request pin
   output logic                  wake_request_n,
   output logic                  wake_request_oe_n,
   // interrupt
   output logic                  irq,
   // transmit, led and fan pins
   input  wire logic             infrared_transmit,
   input  wire logic             infrared_transmit_2,
   input  wire logic             serial2_transmit,
   input  wire logic             led_out_a,
   input  wire logic             led_out_b,
   output logic                  ir_tx2_pin,
   output logic                  shared_tx_pin,
   output logic                  led_pin_a,
   output logic                  led_pin_b,
   output logic                  fan_ctl_pin_a,
   output logic                  fan_ctl_pin_b,
   input  wire logic [1:0]       fan_ctl_drive,
   // retained gpio pin
   input  wire logic             retained_cfg_in,
   input  wire logic             retained_alt_out,
   output logic                  retained_cfg_pin,
   output logic                  retained_cfg_oe_n
);
   tpw_state_t       st;
   tpw_state_t       next_st;
   logic [5:0]       pin_sync;
   logic             pg_sync;
   logic [2:0]       int_sync;
   logic [7:0]       raw;
   logic [7:0]       prev;
   logic [7:0]       event_edge;
   logic             main_rst;
   logic             retained_val;

   // synchronise pins and main power good
   tpw_sync #(.WIDTH(10)) u_sync (
      .clk   (clk),
      .reset (reset),
      .din   ({pins, main_power_good, consumer_infrared, key_match, tach_event}),
      .dout  ({pin_sync, pg_sync, int_sync})
   );

   // raw source levels, event active high; non-wake pins not connected
   always_comb begin
      raw = 8'h00;
      raw[`TPW_SRC_RI1]   = ~pin_sync[5];
      raw[`TPW_SRC_RI2]   = ~pin_sync[4];
      raw[`TPW_SRC_KBD]   = ~pin_sync[3];
      raw[`TPW_SRC_MOUSE] = ~pin_sync[2];
      raw[`TPW_SRC_CIR]   = int_sync[2] | pin_sync[1];
      raw[`TPW_SRC_KEY]   = int_sync[1];
      raw[`TPW_SRC_TACH]  = int_sync[0];
      raw[`TPW_SRC_GPIO]  = pin_sync[0];
   end

   logic unused_nonwake;
   assign unused_nonwake = non_wake_pin_a ^ non_wake_pin_b ^ non_wake_pin_c;

   // edge detector starts at the reset-time raw level, no false event
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev <= `TPW_RAW_IDLE;
      end else begin
         prev <= raw;
      end
   end
   assign event_edge = raw & ~prev;
   assign main_rst   = main_por | hard_reset;

   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      // power tracking
      if (pg_sync) begin
         next_st.power = TPW_MAIN_ON;
      end else begin
         next_st.power = TPW_OFF;
      end
      // register writes, only while main power good
      if (wr && pg_sync) begin
         case (addr)
            `TPW_ADDR_STATUS:   next_st.status   = st.status & ~wdata;
            `TPW_ADDR_ENABLE:   next_st.enable   = wdata;
            `TPW_ADDR_MASK:     next_st.mask     = wdata;
            `TPW_ADDR_IRQ_STAT: next_st.irq_stat = st.irq_stat & ~wdata;
            `TPW_ADDR_CTRL:     next_st.ctrl     = wdata;
            `TPW_ADDR_GPCFG:    next_st.gpcfg    = wdata;
            default: begin
            end
         endcase
      end
      // event capture, set wins over clear
      next_st.status   = next_st.status | event_edge;
      next_st.irq_stat = next_st.irq_stat | event_edge;
      // main reset clears activate and selection bits only
      if (main_rst) begin
         next_st.ctrl[`TPW_CTRL_SP2_ACT]  = 1'b0;
         next_st.ctrl[`TPW_CTRL_SERIAL2_TRANSMIT_SEL] = 1'b0;
      end
      // reads
      if (rd && pg_sync) begin
         case (addr)
            `TPW_ADDR_STATUS:   next_st.rdata = st.status;
            `TPW_ADDR_ENABLE:   next_st.rdata = st.enable;
            `TPW_ADDR_MASK:     next_st.rdata = st.mask;
            `TPW_ADDR_IRQ_STAT: next_st.rdata = st.irq_stat;
            `TPW_ADDR_CTRL:     next_st.rdata = st.ctrl;
            `TPW_ADDR_GPCFG:    next_st.rdata = st.gpcfg;
            `TPW_ADDR_PINSTATE: next_st.rdata = raw;
            default:            next_st.rdata = 8'h00;
         endcase
      end
   end

   // trickle por clears everything
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st.status   <= `TPW_RST_BYTE;
         st.enable   <= `TPW_RST_BYTE;
         st.mask     <= `TPW_RST_BYTE;
         st.irq_stat <= `TPW_RST_BYTE;
         st.ctrl     <= `TPW_RST_BYTE;
         st.gpcfg    <= `TPW_RST_BYTE;
         st.rdata    <= 8'h00;
         st.power    <= TPW_OFF;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign irq   = |(st.irq_stat & st.mask);

   // open drain wake request, oe_n low while pulling low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wake_request_n    <= 1'b0;
         wake_request_oe_n <= 1'b1;
      end else begin
         wake_request_n    <= 1'b0;
         wake_request_oe_n <= ~|(st.status & st.enable);
      end
   end

   // transmit, led, fan and retained pins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ir_tx2_pin       <= 1'b0;
         shared_tx_pin    <= 1'b0;
         led_pin_a        <= 1'b0;
         led_pin_b        <= 1'b0;
         fan_ctl_pin_a    <= 1'b0;
         fan_ctl_pin_b    <= 1'b0;
         retained_cfg_pin <= 1'b0;
         retained_cfg_oe_n <= 1'b1;
      end else begin
         if (main_rst || !st.ctrl[`TPW_CTRL_SP2_ACT]) begin
            ir_tx2_pin <= 1'b0;
         end else begin
            ir_tx2_pin <= infrared_transmit_2;
         end
         if (main_rst || !st.ctrl[`TPW_CTRL_SP2_ACT] || !st.ctrl[`TPW_CTRL_SERIAL2_TRANSMIT_SEL]) begin
            shared_tx_pin <= 1'b0;
         end else if (st.ctrl[`TPW_CTRL_IR_EN]) begin
            shared_tx_pin <= infrared_transmit;
         end else begin
            shared_tx_pin <= serial2_transmit;
         end
         led_pin_a <= st.ctrl[`TPW_CTRL_LED_A] & led_out_a;
         led_pin_b <= st.ctrl[`TPW_CTRL_LED_B] & led_out_b;
         if (main_rst || st.power == TPW_OFF) begin
            fan_ctl_pin_a <= 1'b0;
            fan_ctl_pin_b <= 1'b0;
         end else begin
            fan_ctl_pin_a <= fan_ctl_drive[0];
            fan_ctl_pin_b <= fan_ctl_drive[1];
         end
         retained_cfg_pin  <= retained_val;
         retained_cfg_oe_n <= ~st.gpcfg[`TPW_GPCFG_DIR] |
                              (st.gpcfg[`TPW_GPCFG_OD] & retained_val);
      end
   end

   // without main power the pin falls back to plain gpio, config kept
   always_comb begin
      if (st.power == TPW_MAIN_ON) begin
         retained_val = retained_alt_out ^ st.gpcfg[`TPW_GPCFG_INV];
      end else begin
         retained_val = st.gpcfg[`TPW_GPCFG_OUT] ^ st.gpcfg[`TPW_GPCFG_INV];
      end
      retained_val = retained_val | (1'b0 & retained_cfg_in & unused_nonwake);
   end
endmodule // tpw_wake

// *** testbench/tpw_chip_model.sv ***
// Purpose: chipset side of the wake request line
// Assumes: open-drain line with pull-up
// Notes: released line reads high
`timescale 1ns/1ps
module tpw_chip_model (
   // wake pin drive from the block
   input  wire logic wake_request_n,
   input  wire logic wake_request_oe_n,
   // resolved line seen by the chipset
   output logic      wake_line
);
   assign wake_line = wake_request_oe_n ? 1'b1 : wake_request_n;
endmodule // tpw_chip_model

// *** testbench/tpw_wake_asserts.sv ***
// Purpose: port checker for tpw_wake
// Assumes: one trickle clock, async reset
// Notes: bound to tpw_wake
`timescale 1ns/1ps
module tpw_wake_asserts
   import tpw_pkg::*;
(
   // clock and resets
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       main_por,
   input  wire logic       hard_reset,
   input  wire logic       main_power_good,
   // register port
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic [7:0] rdata,
   // pins
   input  wire logic       wake_request_n,
   input  wire logic       wake_request_oe_n,
   input  wire logic       irq,
   input  wire logic       ir_tx2_pin,
   input  wire logic       shared_tx_pin,
   input  wire logic       fan_ctl_pin_a,
   input  wire logic       fan_ctl_pin_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_wake_low:
      assert property (!wake_request_n) else $error("wake level not low");
   a_fan_low_rst:
      assert property ((main_por || hard_reset) |=> !fan_ctl_pin_a && !fan_ctl_pin_b)
      else $error("fan pin high after reset");
   a_fan_main_off:
      assert property (!main_power_good [*5] |-> !fan_ctl_pin_a && !fan_ctl_pin_b)
      else $error("fan pin high with main off");
   a_tx_low_rst:
      assert property ((main_por || hard_reset) |=> !shared_tx_pin && !ir_tx2_pin)
      else $error("transmit pin high after reset");
   a_tx2_held:
      assert property (main_por ##1 !wr [*3] |-> !ir_tx2_pin)
      else $error("second transmit pin released early");
   a_no_decode:
      assert property (!main_power_good [*4] ##0 rd |=> rdata == 8'h00)
      else $error("read decoded with main off");
   a_oe_after_rst:
      assert property ($fell(reset) |-> wake_request_oe_n) else $error("wake driven at reset");
   a_irq_after_rst:
      assert property ($fell(reset) |-> !irq) else $error("irq high at reset");
   c_wake: cover property ($fell(wake_request_oe_n));
   c_irq: cover property ($rose(irq));
   c_por: cover property (main_por ##1 !main_por);
endmodule // tpw_wake_asserts

bind tpw_wake tpw_wake_asserts u_chk (.clk, .reset, .main_por, .hard_reset,
   .main_power_good, .wr, .rd, .rdata, .wake_request_n, .wake_request_oe_n, .irq,
   .ir_tx2_pin, .shared_tx_pin, .fan_ctl_pin_a, .fan_ctl_pin_b);

// *** testbench/tpw_wake_bench.sv ***
// Purpose: self-checking bench for tpw_wake
// Assumes: 10 MHz clock, chipset model on wake line
// Notes: wake sources driven as one active-high vector
`timescale 1ns/1ps
`include "tpw_defines.svh"
module tpw_wake_bench;
   import tpw_pkg::*;
   logic       clk, reset, main_por, hard_reset, main_power_good, wr, rd, irq;
   logic [7:0] addr, wdata, rdata, src, d;
   logic [2:0] nw;
   logic [4:0] tx;
   tpw_pins_t  pins;
   logic       wake_request_n, wake_request_oe_n, wake_line, ir_tx2_pin, shared_tx_pin;
   logic       led_pin_a, led_pin_b, fan_ctl_pin_a, fan_ctl_pin_b;
   logic       ralt, ret_pin, ret_oe_n;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   assign pins = {~src[0], ~src[1], ~src[2], ~src[3], src[4], src[7]};
   tpw_wake dut (.clk, .reset, .main_por, .hard_reset, .main_power_good, .addr, .wdata,
      .wr, .rd, .rdata, .pins, .consumer_infrared(src[4]), .key_match(src[5]),
      .tach_event(src[6]), .non_wake_pin_a(nw[0]), .non_wake_pin_b(nw[1]),
      .non_wake_pin_c(nw[2]), .wake_request_n, .wake_request_oe_n, .irq,
      .infrared_transmit(tx[0]), .infrared_transmit_2(tx[1]), .serial2_transmit(tx[2]),
      .led_out_a(tx[3]), .led_out_b(tx[4]), .ir_tx2_pin, .shared_tx_pin, .led_pin_a,
      .led_pin_b, .fan_ctl_pin_a, .fan_ctl_pin_b, .fan_ctl_drive(2'b11),
      .retained_cfg_in(1'b0), .retained_alt_out(ralt), .retained_cfg_pin(ret_pin),
      .retained_cfg_oe_n(ret_oe_n));
   tpw_chip_model u_chip (.wake_request_n, .wake_request_oe_n, .wake_line);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(string n, logic [7:0] s, logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic t_wake();
      wreg(`TPW_ADDR_ENABLE, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk) src <= 8'h01 << i;
         repeat (8) @(posedge clk);
         rreg(`TPW_ADDR_STATUS);
         chk("status", d, 8'h01 << i);
         chk("wake", {7'h00, wake_line}, 8'h00);
         @(posedge clk) src <= 8'h00;
         wreg(`TPW_ADDR_STATUS, 8'hFF);
         repeat (3) @(posedge clk);
         chk("idle", {7'h00, wake_line}, 8'h01);
      end
   endtask
   task automatic t_irq();
      wreg(`TPW_ADDR_ENABLE, 8'hBF);
      wreg(`TPW_ADDR_MASK, 8'h40);
      @(posedge clk) src <= 8'h40;
      repeat (8) @(posedge clk);
      chk("tach off", {7'h00, wake_line}, 8'h01);
      chk("irq", {7'h00, irq}, 8'h01);
      wreg(`TPW_ADDR_MASK, 8'h00);
      #1 chk("masked", {7'h00, irq}, 8'h00);
      wreg(`TPW_ADDR_MASK, 8'h40);
      wreg(`TPW_ADDR_IRQ_STAT, 8'hFF);
      #1 chk("cleared", {7'h00, irq}, 8'h00);
      @(posedge clk) src <= 8'h00;
      wreg(`TPW_ADDR_STATUS, 8'hFF);
   endtask
   task automatic t_pg();
      @(posedge clk) main_power_good <= 1'b0;
      repeat (4) @(posedge clk);
      wreg(`TPW_ADDR_ENABLE, 8'h00);
      rreg(`TPW_ADDR_ENABLE);
      chk("off read", d, 8'h00);
      @(posedge clk) src <= 8'h04;
      repeat (8) @(posedge clk);
      chk("off wake", {7'h00, wake_line}, 8'h00);
      @(posedge clk) main_power_good <= 1'b1;
      src <= 8'h00;
      repeat (4) @(posedge clk);
      rreg(`TPW_ADDR_ENABLE);
      chk("kept", d, 8'hBF);
      rreg(`TPW_ADDR_STATUS);
      chk("kept status", d, 8'h04);
      wreg(`TPW_ADDR_STATUS, 8'hFF);
      @(posedge clk) nw <= 3'h7;
      repeat (8) @(posedge clk);
      rreg(`TPW_ADDR_STATUS);
      chk("non wake", d, 8'h00);
   endtask
   task automatic t_tx();
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) tx <= 5'h1F;
         {hard_reset, main_por} <= k ? 2'b10 : 2'b01;
         @(posedge clk) {hard_reset, main_por} <= 2'b00;
         #1 chk("tx low", {4'h0, fan_ctl_pin_a, fan_ctl_pin_b, shared_tx_pin, ir_tx2_pin},
            8'h00);
         repeat (2) @(posedge clk);
      end
      wreg(`TPW_ADDR_CTRL, 8'h01);
      repeat (2) @(posedge clk);
      chk("tx2 on", {6'h00, shared_tx_pin, ir_tx2_pin}, 8'h01);
      wreg(`TPW_ADDR_CTRL, 8'h07);
      @(posedge clk) tx <= 5'h1E;
      repeat (2) @(posedge clk);
      chk("ir sel", {6'h00, shared_tx_pin, ir_tx2_pin}, 8'h01);
      wreg(`TPW_ADDR_CTRL, 8'h1B);
      repeat (2) @(posedge clk);
      chk("serial sel", {4'h0, led_pin_a, led_pin_b, shared_tx_pin, ir_tx2_pin},
         8'h0F);
   endtask
   task automatic t_ret();
      wreg(`TPW_ADDR_GPCFG, 8'h0B);
      repeat (2) @(posedge clk);
      chk("ret on", {6'h00, ret_pin, ret_oe_n}, 8'h02);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) main_power_good <= 1'b0;
         repeat (6) @(posedge clk);
         chk("ret off", {6'h00, ret_pin, ret_oe_n}, k ? 8'h03 : 8'h00);
         chk("led off", {6'h00, led_pin_a, led_pin_b}, 8'h03);
         @(posedge clk) main_power_good <= 1'b1;
         repeat (4) @(posedge clk);
         wreg(`TPW_ADDR_GPCFG, 8'h0D);
      end
      repeat (2) @(posedge clk);
      chk("ret od low", {6'h00, ret_pin, ret_oe_n}, 8'h00);
      @(posedge clk) ralt <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ret od high", {6'h00, ret_pin, ret_oe_n}, 8'h03);
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      {reset, main_por, hard_reset, main_power_good, wr, rd} = 6'b100100;
      {addr, wdata, src, nw, tx} = '0;
      ralt = 1'b0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      t_wake();
      t_irq();
      t_pg();
      t_tx();
      t_ret();
      @(posedge clk) reset <= 1'b1;
      @(posedge clk) reset <= 1'b0;
      repeat (5) @(posedge clk);
      rreg(`TPW_ADDR_ENABLE);
      chk("reset enable", d, 8'h00);
      rreg(`TPW_ADDR_STATUS);
      chk("reset status", d, 8'h00);
      finish_test();
   end
endmodule // tpw_wake_bench
